// *** design/brc_addr_gen.sv ***
// Internal burst address counter: loads the start address, then steps.
// Assumes load and step are never high together except load winning.
`timescale 1ns/1ps

module brc_addr_gen
  import brc_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       load,
  input  wire brc_addr_t  load_addr,
  input  wire logic       step,
  input  wire logic       wrap,
  input  wire logic [2:0] len_code,
  output      brc_addr_t  addr
);

  typedef struct packed {
    brc_addr_t addr;
  } brc_ag_st_t;

  brc_ag_st_t st_reg;
  brc_ag_st_t st_next;

  // ----------------------------------------------------------------
  // Counter
  // ----------------------------------------------------------------
  always_comb begin
    st_next = st_reg;
    if (load) begin
      st_next.addr = load_addr;
    end else if (step) begin
      st_next.addr = brc_next_addr(st_reg.addr, wrap, len_code);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign addr = st_reg.addr;

endmodule : brc_addr_gen

// *** design/brc_cfg_reg.sv ***
// Burst read configuration register with write port and read-back.
// Assumes the write strobe is a one-cycle pulse from the command decoder.
`timescale 1ns/1ps

module brc_cfg_reg
  import brc_pkg::*;
#(
  parameter bit HIGH_DENSITY = 1'b0
) (
  input  wire logic                  clk,
  input  wire logic                  rst_n,
  input  wire logic                  pd_n,
  input  wire logic                  wr,
  input  wire logic [`BRC_REG_W-1:0] wdata,
  output      logic [`BRC_REG_W-1:0] rdata,
  brc_cfg_if.src                     cfg
);

  typedef struct packed {
    logic [`BRC_REG_W-1:0] cfg_val;
  } brc_cfg_st_t;

  brc_cfg_st_t st_reg;
  brc_cfg_st_t st_next;

  // ----------------------------------------------------------------
  // Register update
  // ----------------------------------------------------------------
  // hold until rewrite, default on power-down
  always_comb begin
    st_next = st_reg;
    if (!pd_n) begin
      st_next.cfg_val = `BRC_CFG_RESET;
    end else if (wr) begin
      st_next.cfg_val = wdata;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= '{cfg_val: `BRC_CFG_RESET};
    end else begin
      st_reg <= st_next;
    end
  end

  // Read-back shows the stored edge bit even where it has no effect
  assign rdata = st_reg.cfg_val;

  // ----------------------------------------------------------------
  // Field decode
  // ----------------------------------------------------------------
  // read select
  assign cfg.async_read     = st_reg.cfg_val[`BRC_READ_SEL_BIT];
  assign cfg.standby_dis    = st_reg.cfg_val[`BRC_STBY_DIS_BIT];
  assign cfg.xlat_code      = st_reg.cfg_val[`BRC_XLAT_MSB:`BRC_XLAT_LSB];
  assign cfg.two_cycle_beat = st_reg.cfg_val[`BRC_YLAT_BIT];
  assign cfg.ready_early    = st_reg.cfg_val[`BRC_RDY_TIME_BIT];
  // edge select, forced rising in the larger variant
  assign cfg.rising_edge    = HIGH_DENSITY | st_reg.cfg_val[`BRC_EDGE_BIT];
  assign cfg.wrap           = ~st_reg.cfg_val[`BRC_WRAP_BIT];
  assign cfg.len_code       = st_reg.cfg_val[`BRC_LEN_MSB:`BRC_LEN_LSB];

endmodule : brc_cfg_reg

// *** design/brc_top.sv ***
// Burst read sequencer top: configuration register, active-edge
// detection of the burst clock, latency, wait states and beat pacing.
// Assumes K, L_N, B_N, E_N, A are synchronous to CLK and K is slower.
`timescale 1ns/1ps

module brc_top
  import brc_pkg::*;
#(
  parameter bit HIGH_DENSITY = 1'b0
) (
  input  wire logic                  CLK,
  input  wire logic                  RESET_N,
  input  wire logic                  PD_N,
  input  wire logic                  CFG_WR,
  input  wire logic [`BRC_REG_W-1:0] CFG_WDATA,
  output      logic [`BRC_REG_W-1:0] CFG_RDATA,
  input  wire logic                  K,
  input  wire logic                  E_N,
  input  wire logic                  L_N,
  input  wire logic                  B_N,
  input  wire brc_addr_t             A,
  output      brc_addr_t             BURST_ADDR,
  output      logic                  DATA_STEP,
  output      logic                  R,
  output      logic                  BURST_ACTIVE,
  output      logic                  STANDBY
);

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [1:0] sync;
  } brc_rst_st_t;

  brc_rst_st_t rst_reg;
  brc_rst_st_t rst_next;
  logic        rst_n;

  // Two-stage release keeps the deassertion clean
  always_comb begin
    rst_next      = rst_reg;
    rst_next.sync = {rst_reg.sync[0], 1'b1};
  end

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      rst_reg <= '0;
    end else begin
      rst_reg <= rst_next;
    end
  end

  assign rst_n = rst_reg.sync[1];

  // ----------------------------------------------------------------
  // Configuration register
  // ----------------------------------------------------------------
  brc_cfg_if cfg ();

  brc_cfg_reg #(
    .HIGH_DENSITY (HIGH_DENSITY)
  ) u_cfg (
    .clk   (CLK),
    .rst_n (rst_n),
    .pd_n  (PD_N),
    .wr    (CFG_WR),
    .wdata (CFG_WDATA),
    .rdata (CFG_RDATA),
    .cfg   (cfg.src)
  );

  // ----------------------------------------------------------------
  // Sequencer state
  // ----------------------------------------------------------------
  typedef struct packed {
    brc_state_t state;
    logic       k_prev;
    logic [3:0] lat_cnt;
    logic [1:0] wait_cnt;
    logic [3:0] beat_cnt;
    logic       y_phase;
    logic       step;
  } brc_seq_st_t;

  brc_seq_st_t st_reg;
  brc_seq_st_t st_next;

  logic       act_edge;
  logic       start;
  logic       load;
  logic       adv;
  logic       linear;
  logic [1:0] start_waits;
  logic [3:0] len_beats;
  brc_addr_t  cur_addr;

  // pick the active burst clock edge
  assign act_edge = cfg.rising_edge ? (K & ~st_reg.k_prev) : (~K & st_reg.k_prev);

  // a burst only starts in synchronous mode
  assign start = act_edge & ~cfg.async_read & ~E_N & ~L_N;

  // waits apply to continuous or non-wrapping bursts only
  assign linear      = ~cfg.wrap | (cfg.len_code == `BRC_LEN_CONT);
  assign start_waits = brc_wait_states(A, linear);
  assign len_beats   = brc_len_beats(cfg.len_code);

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    st_next        = st_reg;
    st_next.k_prev = K;
    st_next.step   = 1'b0;
    load           = 1'b0;
    adv            = 1'b0;
    if (!PD_N || E_N || cfg.async_read) begin
      // Abort on chip deselect, power-down or asynchronous mode
      st_next.state = ST_IDLE;
    end else if (start) begin
      // latency counted in active edges from the latch edge
      load             = 1'b1;
      st_next.state    = ST_LAT;
      st_next.lat_cnt  = brc_xlat_edges(cfg.xlat_code);
      st_next.wait_cnt = start_waits;
      st_next.beat_cnt = 4'h1;
      st_next.y_phase  = 1'b0;
    end else if (act_edge) begin
      case (st_reg.state)
        ST_LAT: begin
          st_next.lat_cnt = 4'(st_reg.lat_cnt - 4'h1);
          if (st_reg.lat_cnt == 4'h1) begin
            if (st_reg.wait_cnt != 2'h0) begin
              st_next.state = ST_WAIT;
            end else begin
              st_next.state = ST_BURST;
              st_next.step  = 1'b1;
            end
          end
        end
        ST_WAIT: begin
          // address held through the wait edges
          st_next.wait_cnt = 2'(st_reg.wait_cnt - 2'h1);
          if (st_reg.wait_cnt == 2'h1) begin
            st_next.state = ST_BURST;
            st_next.step  = 1'b1;
          end
        end
        ST_BURST: begin
          // every edge or every second edge
          st_next.y_phase = cfg.two_cycle_beat & ~st_reg.y_phase;
          if ((!cfg.two_cycle_beat || st_reg.y_phase) && !B_N) begin
            // bounded bursts stop after their length
            if (len_beats != 4'h0 && st_reg.beat_cnt == len_beats) begin
              st_next.state = ST_DONE;
            end else begin
              adv              = 1'b1;
              st_next.step     = 1'b1;
              st_next.beat_cnt = 4'(st_reg.beat_cnt + 4'h1);
            end
          end
        end
        ST_IDLE, ST_DONE: begin
          st_next.state = st_reg.state;
        end
        default: begin
          st_next.state = ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= '{state: ST_IDLE, default: '0};
    end else begin
      st_reg <= st_next;
    end
  end

  // ----------------------------------------------------------------
  // Address counter
  // ----------------------------------------------------------------
  brc_addr_gen u_addr (
    .clk       (CLK),
    .rst_n     (rst_n),
    .load      (load),
    .load_addr (A),
    .step      (adv),
    .wrap      (cfg.wrap),
    .len_code  (cfg.len_code),
    .addr      (cur_addr)
  );

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign BURST_ADDR   = cur_addr;
  assign DATA_STEP    = st_reg.step;
  assign BURST_ACTIVE = (st_reg.state != ST_IDLE);

  // ready low on each invalid-data edge, or one active edge earlier
  // The edge that presents the first datum must never see ready low
  always_comb begin
    if (cfg.ready_early) begin
      R = ~(((st_reg.state == ST_LAT) && (st_reg.lat_cnt == 4'h2) &&
             (st_reg.wait_cnt != 2'h0)) ||
            ((st_reg.state == ST_LAT) && (st_reg.lat_cnt == 4'h1) &&
             (st_reg.wait_cnt > 2'h1)) ||
            ((st_reg.state == ST_WAIT) && (st_reg.wait_cnt > 2'h2)));
    end else begin
      R = ~(((st_reg.state == ST_LAT) && (st_reg.lat_cnt == 4'h1) &&
             (st_reg.wait_cnt != 2'h0)) ||
            ((st_reg.state == ST_WAIT) && (st_reg.wait_cnt > 2'h1)));
    end
  end

  // standby only when deselected and not disabled
  assign STANDBY = E_N & ~cfg.standby_dis;

endmodule : brc_top

// *** include/brc_cfg.svh ***
// Constants for the burst read configuration sequencer: register layout,
// reset value, field codes and timing. Included by the package; the modules do not include it.
// Functional notes
// - Read select bit picks synchronous burst reads at 0, asynchronous at 1, and resets to 1.
// - Standby disable bit lets standby happen at 0 (reset value) and blocks it at 1.
// - Latency codes 1 to 6 give 3 to 8 clock edges; codes 0 and 7 are reserved for the host.
// - Inter-beat bit at 0 moves data every burst clock, at 1 every second burst clock.
// - Ready timing bit at 0 drops ready on the invalid edge, at 1 one data cycle earlier.
// - Clock edge bit picks the falling burst clock edge at 0 and the rising edge at 1.
// - In the larger variant the edge and qualifier bits do nothing and rising is active.
// - Wrap bit at 0 keeps 4 or 8 beat bursts in their aligned group, at 1 runs linearly.
// - Length codes 1, 2 and 7 give 4, 8 and continuous beats; other codes are reserved.
// - Continuous or linear bursts starting at 29, 30 or 31 modulo 32 get 1 to 3 waits.
// - Wrapping 4 or 8 beat bursts count the low address bits modulo the group size.
// - Linear and continuous bursts count the address straight across group edges.
// - The register holds until rewritten and returns to its reset value on reset or power-down.
// - While ready is low at an active edge no new data appears and the address holds.
`ifndef BRC_CFG_SVH
`define BRC_CFG_SVH

// ----------------------------------------------------------------
// Widths
// ----------------------------------------------------------------
`define BRC_ADDR_W        20
`define BRC_REG_W         16

// ----------------------------------------------------------------
// Register field positions
// ----------------------------------------------------------------
`define BRC_READ_SEL_BIT  15
`define BRC_STBY_DIS_BIT  14
`define BRC_XLAT_MSB      13
`define BRC_XLAT_LSB      11
`define BRC_YLAT_BIT      9
`define BRC_RDY_TIME_BIT  8
`define BRC_QUAL_BIT      7
`define BRC_EDGE_BIT      6
`define BRC_WRAP_BIT      3
`define BRC_LEN_MSB       2
`define BRC_LEN_LSB       0

// ----------------------------------------------------------------
// Reset value and codes
// ----------------------------------------------------------------
`define BRC_CFG_RESET     16'h8000
`define BRC_LEN_4         3'h1
`define BRC_LEN_8         3'h2
`define BRC_LEN_CONT      3'h7
`define BRC_XLAT_MIN_CODE 3'h1
`define BRC_XLAT_MAX_CODE 3'h6
`define BRC_XLAT_OFFSET   4'h2
`define BRC_WAIT_BASE     5'h1c

`endif

// *** include/brc_cfg_if.sv ***
// Decoded configuration fields passed from the register to the sequencer.
// Assumes one clock domain; fields are register outputs.
`timescale 1ns/1ps

interface brc_cfg_if;
  logic       async_read;
  logic       standby_dis;
  logic [2:0] xlat_code;
  logic       two_cycle_beat;
  logic       ready_early;
  logic       rising_edge;
  logic       wrap;
  logic [2:0] len_code;

  modport src (output async_read, standby_dis, xlat_code, two_cycle_beat,
               ready_early, rising_edge, wrap, len_code);
  modport snk (input async_read, standby_dis, xlat_code, two_cycle_beat,
               ready_early, rising_edge, wrap, len_code);
endinterface : brc_cfg_if

// *** include/brc_pkg.sv ***
// Types and shared arithmetic of the burst read configuration sequencer.
// Assumes brc_cfg.svh is on the include path.
`include "brc_cfg.svh"

package brc_pkg;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef logic [`BRC_ADDR_W-1:0] brc_addr_t;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_LAT,
    ST_WAIT,
    ST_BURST,
    ST_DONE
  } brc_state_t;

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  // Edges from latch to first data; reserved codes fall back to the shortest
  function automatic logic [3:0] brc_xlat_edges(input logic [2:0] code);
    if (code < `BRC_XLAT_MIN_CODE || code > `BRC_XLAT_MAX_CODE) begin
      brc_xlat_edges = 4'h3;
    end else begin
      brc_xlat_edges = {1'b0, code} + `BRC_XLAT_OFFSET;
    end
  endfunction : brc_xlat_edges

  // Beats in a bounded burst, zero meaning unbounded
  function automatic logic [3:0] brc_len_beats(input logic [2:0] code);
    case (code)
      `BRC_LEN_4: brc_len_beats = 4'h4;
      `BRC_LEN_8: brc_len_beats = 4'h8;
      default:    brc_len_beats = 4'h0;
    endcase
  endfunction : brc_len_beats

  // Wait states near a 32 double-word boundary
  function automatic logic [1:0] brc_wait_states(input brc_addr_t a, input logic linear);
    if (linear && a[4:0] > `BRC_WAIT_BASE) begin
      brc_wait_states = 2'(a[4:0] - `BRC_WAIT_BASE);
    end else begin
      brc_wait_states = 2'h0;
    end
  endfunction : brc_wait_states

  // Next burst address, wrapping in the group or counting linearly
  function automatic brc_addr_t brc_next_addr(input brc_addr_t a, input logic wrap,
                                              input logic [2:0] len);
    brc_addr_t n;
    n = a + brc_addr_t'(1);
    if (wrap && len == `BRC_LEN_4) begin
      n = {a[`BRC_ADDR_W-1:2], 2'(a[1:0] + 2'h1)};
    end else if (wrap && len == `BRC_LEN_8) begin
      n = {a[`BRC_ADDR_W-1:3], 3'(a[2:0] + 3'h1)};
    end
    brc_next_addr = n;
  endfunction : brc_next_addr

endpackage : brc_pkg

// *** tb/brc_host_model.sv ***
// Host burst controller model: burst clock, latch, advance, address.
// Assumes CLK from the bench; K stands low outside frames.
`timescale 1ns/1ps

module brc_host_model
  import brc_pkg::*;
(
  input  wire logic CLK,
  output logic      K,
  output logic      E_N,
  output logic      L_N,
  output logic      B_N,
  output brc_addr_t A
);
  initial begin
    K = 1'b0;
    E_N = 1'b1;
    L_N = 1'b1;
    B_N = 1'b1;
    A = '0;
  end

  // One frame of per K periods, eight CLK each; latch in period 0
  task automatic run(input brc_addr_t a, input int per, input int st);
    for (int p = 0; p < per; p++) begin
      @(posedge CLK);
      E_N <= 1'b0;
      L_N <= (p != 0);
      A <= (p == 0) ? a : ~a; // Released address is not held
      B_N <= (p >= st && p < st + 2);
      K <= 1'b1;
      repeat (4) @(posedge CLK);
      K <= 1'b0;
      repeat (3) @(posedge CLK);
    end
    @(posedge CLK);
    E_N <= 1'b1;
    B_N <= 1'b1;
    A <= ~a;
  endtask : run
endmodule : brc_host_model

// *** tb/brc_top_checker.sv ***
// Checker: port-level assertions for the burst read sequencer top.
// Assumes each K level lasts several CLK cycles; bound into brc_top.
`timescale 1ns/1ps

module brc_top_checker
  import brc_pkg::*;
#(
  parameter bit HIGH_DENSITY = 1'b0
) (
  input wire logic        CLK,
  input wire logic        RESET_N,
  input wire logic        PD_N,
  input wire logic        CFG_WR,
  input wire logic [15:0] CFG_WDATA,
  input wire logic [15:0] CFG_RDATA,
  input wire logic        K,
  input wire logic        E_N,
  input wire logic        L_N,
  input wire logic        B_N,
  input wire brc_addr_t   A,
  input wire brc_addr_t   BURST_ADDR,
  input wire logic        DATA_STEP,
  input wire logic        R,
  input wire logic        BURST_ACTIVE,
  input wire logic        STANDBY
);
  // ----------------------------------------
  // Helper logic
  // ----------------------------------------
  logic       k_d;
  logic [1:0] acts;
  logic       have_prev;
  brc_addr_t  prev_addr;
  wire logic  act = (HIGH_DENSITY || CFG_RDATA[6]) ? (K && !k_d) : (!K && k_d);
  wire logic  start = act && !L_N && !E_N && !CFG_RDATA[15];
  wire logic  w4 = !CFG_RDATA[3] && CFG_RDATA[2:0] == 3'h1;
  wire logic  w8 = !CFG_RDATA[3] && CFG_RDATA[2:0] == 3'h2;
  // Own model of the next beat, kept apart from the design's
  wire brc_addr_t exp_next = w4 ? {prev_addr[19:2], 2'(prev_addr[1:0] + 2'h1)}
                           : w8 ? {prev_addr[19:3], 3'(prev_addr[2:0] + 3'h1)}
                           : prev_addr + 20'h1;

  // Active edges since last beat, saturating so it never wraps
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      k_d <= 1'b0;
      acts <= 2'h3;
      have_prev <= 1'b0;
      prev_addr <= '0;
    end else begin
      k_d <= K;
      if (DATA_STEP) acts <= {1'b0, act};
      else if (act && acts != 2'h3) acts <= acts + 2'h1;
      if (start || E_N || !PD_N) have_prev <= 1'b0;
      else if (DATA_STEP) have_prev <= 1'b1;
      if (DATA_STEP) prev_addr <= BURST_ADDR;
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESET_N);
  sequence s_latch;
    start;
  endsequence
  sequence s_loaded;
    BURST_ACTIVE && BURST_ADDR == $past(A);
  endsequence

  a_latch_load: assert property (s_latch |=> s_loaded)
    else $error("start address not loaded");
  a_pd_restore: assert property (!PD_N |=> CFG_RDATA == `BRC_CFG_RESET)
    else $error("power-down did not restore config");
  a_cfg_write: assert property (CFG_WR && PD_N |=> CFG_RDATA == $past(CFG_WDATA))
    else $error("config write not stored");
  a_cfg_hold: assert property (!CFG_WR && PD_N |=> $stable(CFG_RDATA))
    else $error("config changed without write");
  a_async_idle: assert property (CFG_RDATA[15] && !BURST_ACTIVE |=> !BURST_ACTIVE)
    else $error("burst started in async mode");
  a_standby_map: assert property (STANDBY == (E_N && !CFG_RDATA[14]))
    else $error("standby output wrong");
  a_wait_hold: assert property (act && !R && !CFG_RDATA[8] && L_N
                                |=> !DATA_STEP && $stable(BURST_ADDR))
    else $error("data advanced while not ready");
  a_beat_pace: assert property (DATA_STEP |-> acts >= (CFG_RDATA[9] ? 2'h2 : 2'h1))
    else $error("beats closer than inter-beat latency");
  a_addr_order: assert property (DATA_STEP && have_prev |-> BURST_ADDR == exp_next)
    else $error("burst address order wrong");
endmodule : brc_top_checker

bind brc_top brc_top_checker #(.HIGH_DENSITY(HIGH_DENSITY)) u_chk (
  .CLK(CLK), .RESET_N(RESET_N), .PD_N(PD_N), .CFG_WR(CFG_WR), .CFG_WDATA(CFG_WDATA),
  .CFG_RDATA(CFG_RDATA), .K(K), .E_N(E_N), .L_N(L_N), .B_N(B_N), .A(A),
  .BURST_ADDR(BURST_ADDR), .DATA_STEP(DATA_STEP), .R(R), .BURST_ACTIVE(BURST_ACTIVE),
  .STANDBY(STANDBY));

// *** tb/testbench.sv ***
// Testbench: config register and burst sequencing through the host model.
// Assumes brc_top, its checker and brc_host_model are compiled first.
`timescale 1ns/1ps

module testbench
  import brc_pkg::*;
;
  logic        CLK, RESET_N, PD_N, CFG_WR, K, E_N, L_N, B_N;
  logic        DATA_STEP, R, BURST_ACTIVE, STANDBY, k_d;
  logic [15:0] CFG_WDATA, CFG_RDATA, cur;
  brc_addr_t   A, BURST_ADDR;
  brc_addr_t   q_addr[$];
  int          q_edge[$];
  int          err_total, total_checks, eidx, r_first, rf0, cyc;

  brc_top DUT (.CLK(CLK), .RESET_N(RESET_N), .PD_N(PD_N), .CFG_WR(CFG_WR),
    .CFG_WDATA(CFG_WDATA), .CFG_RDATA(CFG_RDATA), .K(K), .E_N(E_N), .L_N(L_N), .B_N(B_N),
    .A(A), .BURST_ADDR(BURST_ADDR), .DATA_STEP(DATA_STEP), .R(R),
    .BURST_ACTIVE(BURST_ACTIVE), .STANDBY(STANDBY));
  brc_host_model host (.CLK(CLK), .K(K), .E_N(E_N), .L_N(L_N), .B_N(B_N), .A(A));

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic end_sim;
    if (err_total == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : end_sim

  task automatic wr(input logic [15:0] v);
    cur = v;
    @(posedge CLK);
    CFG_WR <= 1'b1;
    CFG_WDATA <= v;
    @(posedge CLK);
    CFG_WR <= 1'b0;
    @(negedge CLK);
    check("cfg", CFG_RDATA, v);
  endtask : wr

  // legal codes, zero reserved, qualifier set
  function automatic logic [15:0] cfg(input logic [2:0] x, input logic y, input logic rdy,
                                      input logic edg, input logic wrp, input logic [2:0] len);
    return {2'b00, x, 1'b0, y, rdy, 1'b1, edg, 2'b00, wrp, len};
  endfunction : cfg

  // Expected next beat address
  function automatic brc_addr_t nxt(input brc_addr_t a, input logic [15:0] c);
    if (!c[3] && c[2:0] == 3'h1) return {a[19:2], 2'(a[1:0] + 2'h1)};
    if (!c[3] && c[2:0] == 3'h2) return {a[19:3], 3'(a[2:0] + 3'h1)};
    return a + 20'h1;
  endfunction : nxt

  // Active edges counted from the latch edge; beats logged with their edge
  always @(posedge CLK) begin
    k_d <= K;
    if (cur[6] ? (K && !k_d) : (!K && k_d)) eidx <= L_N ? eidx + 1 : 0;
    if (DATA_STEP === 1'b1) begin
      q_addr.push_back(BURST_ADDR);
      q_edge.push_back(eidx);
    end
    if (R === 1'b0 && r_first < 0) r_first = eidx;
  end

  // One burst frame, then latency, pacing, count and order compared
  task automatic burst(input logic [15:0] c, input brc_addr_t a, input int per,
                       input int st, input int nb);
    brc_addr_t e;
    int x, y, w, s;
    x = c[13:11] + 2;
    y = c[9] ? 2 : 1;
    w = ((c[3] || c[2:0] == 3'h7) && a[4:0] > 5'h1c) ? a[4:0] - 28 : 0;
    s = (st < per) ? 2 : 0;
    e = a;
    wr(c);
    q_addr.delete();
    q_edge.delete();
    r_first = -1;
    host.run(a, per, st);
    repeat (4) @(posedge CLK);
    check("active", BURST_ACTIVE, 1'b0); // E_N high ends the burst
    check("beats", (c[2:0] == 3'h7) ? q_addr.size() >= nb : q_addr.size() == nb, 1'b1);
    check("first", q_edge[0], x + w);
    check("second", q_edge[1] - q_edge[0], y);
    check("last", q_edge[nb-1] - q_edge[0], (nb - 1) * y + s);
    for (int i = 0; i < nb; i++) begin
      check("addr", q_addr[i], e);
      e = nxt(e, c);
    end
  endtask : burst

  // ----------------------------------------
  // Clock, timeout and main sequence
  // ----------------------------------------
  initial begin
    CLK = 1'b0;
    forever #4 CLK = ~CLK;
  end

  // Longest run is well under this many cycles
  always @(posedge CLK) begin
    cyc++;
    if (cyc > 20000) begin
      err_total++;
      end_sim();
    end
  end

  initial begin
    RESET_N = 1'b0;
    PD_N = 1'b1;
    CFG_WR = 1'b0;
    CFG_WDATA = '0;
    cur = 16'h8000;
    k_d = 1'b0;
    repeat (16) @(posedge CLK);
    RESET_N <= 1'b1;
    repeat (3) @(negedge CLK);
    check("rst cfg", CFG_RDATA, 16'h8000);
    check("rst rdy", R, 1'b1);
    check("rst stby", STANDBY, 1'b1);
    host.run(20'h4, 8, 99);
    repeat (4) @(posedge CLK);
    check("async", q_addr.size(), 0);
    wr(16'hc000);
    check("stby dis", STANDBY, 1'b0);
    burst(cfg(3'h1, 0, 0, 0, 0, 3'h1), 20'h1, 12, 99, 4);
    burst(cfg(3'h6, 0, 0, 1, 0, 3'h2), 20'h1e, 20, 99, 8);
    burst(cfg(3'h2, 1, 0, 0, 1, 3'h1), 20'h5, 20, 99, 4);
    burst(cfg(3'h1, 0, 0, 1, 0, 3'h7), 20'h1d, 16, 99, 6);
    burst(cfg(3'h1, 0, 0, 1, 1, 3'h7), 20'h3f, 18, 99, 6);
    rf0 = r_first;
    burst(cfg(3'h1, 0, 1, 1, 1, 3'h7), 20'h3f, 18, 99, 6);
    check("rdy early", rf0 - r_first, 1);
    burst(cfg(3'h3, 0, 0, 1, 1, 3'h7), 20'h40, 20, 8, 8);
    @(posedge CLK);
    PD_N <= 1'b0;
    @(posedge CLK);
    PD_N <= 1'b1;
    @(negedge CLK);
    check("pd cfg", CFG_RDATA, 16'h8000);
    end_sim();
  end
endmodule : testbench
